// ### pkg/hbc_pkg.sv
// constants shared by the half-bridge chopping control core
package hbc_pkg;
  // ----------------------------------------
  // clock and generator timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned STEPS_PER_PERIOD = 256;
  localparam int unsigned RATE0_HZ = 80;
  localparam int unsigned RATE1_HZ = 100;
  localparam int unsigned RATE2_HZ = 200;
  localparam int unsigned RATE3_HZ = 2000;
  // clocks per duty step, rounded down so no period runs long
  localparam int unsigned STEP_CLKS_0 = CLK_HZ / (RATE0_HZ * STEPS_PER_PERIOD);
  localparam int unsigned STEP_CLKS_1 = CLK_HZ / (RATE1_HZ * STEPS_PER_PERIOD);
  localparam int unsigned STEP_CLKS_2 = CLK_HZ / (RATE2_HZ * STEPS_PER_PERIOD);
  localparam int unsigned STEP_CLKS_3 = CLK_HZ / (RATE3_HZ * STEPS_PER_PERIOD);
  localparam int unsigned PRESC_W = 14;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned RATE_W = 2;

  // ----------------------------------------
  // rate codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    HBC_RATE_80 = 2'b00,
    HBC_RATE_100 = 2'b01,
    HBC_RATE_200 = 2'b10,
    HBC_RATE_2K = 2'b11
  } hbc_rate_e;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SWITCH_ENABLE_REG_A_OFS = 8'h00;
  localparam logic [7:0] CHOP_SELECT_REG_OFS = 8'h04;
  localparam logic [7:0] FREEWHEEL_SELECT_REG_A_OFS = 8'h08;
  localparam logic [7:0] GENERATOR_MAP_REG_OFS = 8'h0C;
  localparam logic [7:0] GENERATOR_RATE_REG_OFS = 8'h10;
  localparam logic [7:0] STATUS_REG_OFS = 8'h14;
  localparam logic [7:0] DUTY_REG_BASE_OFS = 8'h20;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned UPPER_BIT_POS = 0;
  localparam int unsigned LOWER_BIT_POS = 1;
  localparam int unsigned STATUS_STANDBY_POS = 31;
  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] MAP_RESET_GEN1 = 2'b00;
  localparam hbc_rate_e RATE_RESET_VAL = HBC_RATE_80;
endpackage

// ### pkg/hbc_gen_if.sv
// carrier between the core and one chopping generator
`timescale 1ns/100ps
interface hbc_gen_if;
  logic [1:0] rate;
  logic [7:0] duty;
  logic pwm;
  modport ctl (output rate, output duty, input pwm);
  modport gen (input rate, input duty, output pwm);
endinterface

// ### core/hbc_gen.sv
// one chopping generator: 256 steps per period at a selectable rate
`timescale 1ns/100ps
module hbc_gen #(
  parameter int unsigned STEP_CLKS_0 = hbc_pkg::STEP_CLKS_0,
  parameter int unsigned STEP_CLKS_1 = hbc_pkg::STEP_CLKS_1,
  parameter int unsigned STEP_CLKS_2 = hbc_pkg::STEP_CLKS_2,
  parameter int unsigned STEP_CLKS_3 = hbc_pkg::STEP_CLKS_3
) (
  input wire logic pclk,
  input wire logic presetn,
  hbc_gen_if.gen gio
);
  import hbc_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [DUTY_W-1:0] step;
    logic pwm;
  } hbc_gen_s;

  hbc_gen_s st;
  hbc_gen_s next_st;
  logic [PRESC_W-1:0] step_last;

  // ----------------------------------------
  // rate divider and duty compare
  // ----------------------------------------
  always_comb begin
    next_st = st;
    case (gio.rate)
      HBC_RATE_80: step_last = PRESC_W'(STEP_CLKS_0 - 1);
      HBC_RATE_100: step_last = PRESC_W'(STEP_CLKS_1 - 1);
      HBC_RATE_200: step_last = PRESC_W'(STEP_CLKS_2 - 1);
      HBC_RATE_2K: step_last = PRESC_W'(STEP_CLKS_3 - 1);
      default: step_last = PRESC_W'(STEP_CLKS_0 - 1);
    endcase
    if (st.presc >= step_last) begin
      next_st.presc = '0;
      next_st.step = st.step + 8'h01;
    end else begin
      next_st.presc = st.presc + PRESC_W'(1);
    end
    next_st.pwm = (st.step < gio.duty);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign gio.pwm = st.pwm;
endmodule

// ### core/hbc_top.sv
// half-bridge switch control with shared chopping generators behind apb
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
// How it works
// - after reset every bridge runs continuous, switches follow enable bits, no chopping
// - upper and lower switches of each bridge follow their own enable bits
// - both enable bits set keeps the bridge high impedance until one clears
// - standby input low forces every bridge to high impedance
// - awake, upper 1 lower 0 drives the output high
// - awake, upper 0 lower 1 drives the output low
// - awake, both enable bits 0 leaves the output high impedance
// - each bridge has a chop-select bit that turns on chopping
// - chop-select clear means continuous mode; it resets clear
// - sync freewheel drives the opposite switch as complement of the chopped one
// - default asynchronous freewheel: both switches off during chop off time
// - generator select per bridge, two bits with four generators (00b gen 1 through 11b gen 4), three bits with eight
// - after reset every bridge selects generator 1
// - each generator rate field: 00b 80 Hz, 01b 100, 10b 200, 11b 2 kHz
// - each generator has its own independent 8-bit duty
// - rate fields share one register, each duty has its own register
// - four or eight generators, any one mappable to any bridge
// - chopping switches whichever side is enabled; opposite conducts only with sync freewheel
module hbc_top #(
  parameter int unsigned NUM_BRIDGE = 4,
  parameter int unsigned NUM_GEN = 4,
  parameter int unsigned STEP_CLKS_0 = hbc_pkg::STEP_CLKS_0,
  parameter int unsigned STEP_CLKS_1 = hbc_pkg::STEP_CLKS_1,
  parameter int unsigned STEP_CLKS_2 = hbc_pkg::STEP_CLKS_2,
  parameter int unsigned STEP_CLKS_3 = hbc_pkg::STEP_CLKS_3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_input_n,
  output logic [NUM_BRIDGE-1:0] bridge_upper_drive,
  output logic [NUM_BRIDGE-1:0] bridge_lower_drive
);
  import hbc_pkg::*;

  localparam int unsigned MAP_W = $clog2(NUM_GEN);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (NUM_BRIDGE < 1 || NUM_BRIDGE > 15) begin : g_bad_nb
      $error("bridge count must be 1 to 15");
    end
    if (NUM_GEN != 4 && NUM_GEN != 8) begin : g_bad_ng
      $error("generator count must be 4 or 8");
    end
    if (NUM_BRIDGE * MAP_W > 32 || NUM_GEN * RATE_W > 32) begin : g_bad_w
      $error("map or rate fields do not fit one register");
    end
    if (STEP_CLKS_0 < 1 || STEP_CLKS_0 >= (1 << PRESC_W) || STEP_CLKS_1 < 1 ||
        STEP_CLKS_1 >= (1 << PRESC_W) || STEP_CLKS_2 < 1 || STEP_CLKS_2 >= (1 << PRESC_W) ||
        STEP_CLKS_3 < 1 || STEP_CLKS_3 >= (1 << PRESC_W)) begin : g_bad_step
      $error("step counts out of range");
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic stby_s1;
    logic stby_s2;
    logic [NUM_BRIDGE-1:0] upper_on;
    logic [NUM_BRIDGE-1:0] lower_on;
    logic [NUM_BRIDGE-1:0] chop;
    logic [NUM_BRIDGE-1:0] sync_fw;
    logic [NUM_BRIDGE*MAP_W-1:0] gen_sel;
    logic [NUM_GEN*RATE_W-1:0] rate;
    logic [NUM_GEN*DUTY_W-1:0] duty;
    logic [NUM_BRIDGE-1:0] upper_drv;
    logic [NUM_BRIDGE-1:0] lower_drv;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } hbc_top_s;

  hbc_top_s st;
  hbc_top_s next_st;
  logic [NUM_GEN-1:0] gen_pwm;

  // ----------------------------------------
  // generators
  // ----------------------------------------
  hbc_gen_if gen_if[NUM_GEN]();

  generate
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
      assign gen_if[g].rate = st.rate[g*RATE_W +: RATE_W];
      assign gen_if[g].duty = st.duty[g*DUTY_W +: DUTY_W];
      assign gen_pwm[g] = gen_if[g].pwm;
      hbc_gen #(
        .STEP_CLKS_0(STEP_CLKS_0),
        .STEP_CLKS_1(STEP_CLKS_1),
        .STEP_CLKS_2(STEP_CLKS_2),
        .STEP_CLKS_3(STEP_CLKS_3)
      ) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .gio(gen_if[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // register access and switch decode
  // ----------------------------------------
  always_comb begin
    logic hit;
    logic [31:0] rd;
    logic awake;
    logic chopped;
    logic [MAP_W-1:0] sel;
    hit = 1'b0;
    rd = REG_RESET_VAL;
    awake = 1'b0;
    chopped = 1'b0;
    sel = '0;
    next_st = st;

    // standby pin through two flops
    next_st.stby_s1 = standby_input_n;
    next_st.stby_s2 = st.stby_s1;

    // address decode and read mux
    case (paddr)
      SWITCH_ENABLE_REG_A_OFS: begin
        hit = 1'b1;
        for (int i = 0; i < NUM_BRIDGE; i++) begin
          rd[2*i+UPPER_BIT_POS] = st.upper_on[i];
          rd[2*i+LOWER_BIT_POS] = st.lower_on[i];
        end
      end
      CHOP_SELECT_REG_OFS: begin
        hit = 1'b1;
        rd[NUM_BRIDGE-1:0] = st.chop;
      end
      FREEWHEEL_SELECT_REG_A_OFS: begin
        hit = 1'b1;
        rd[NUM_BRIDGE-1:0] = st.sync_fw;
      end
      GENERATOR_MAP_REG_OFS: begin
        hit = 1'b1;
        rd[NUM_BRIDGE*MAP_W-1:0] = st.gen_sel;
      end
      GENERATOR_RATE_REG_OFS: begin
        hit = 1'b1;
        rd[NUM_GEN*RATE_W-1:0] = st.rate;
      end
      STATUS_REG_OFS: begin
        hit = 1'b1;
        for (int i = 0; i < NUM_BRIDGE; i++) begin
          rd[2*i+UPPER_BIT_POS] = st.upper_drv[i];
          rd[2*i+LOWER_BIT_POS] = st.lower_drv[i];
        end
        rd[STATUS_STANDBY_POS] = st.stby_s2;
      end
      default: begin
        for (int g = 0; g < NUM_GEN; g++) begin
          if (paddr == DUTY_REG_BASE_OFS + 8'(g) * REG_STRIDE) begin
            hit = 1'b1;
            rd[DUTY_W-1:0] = st.duty[g*DUTY_W +: DUTY_W];
          end
        end
      end
    endcase

    // one wait state, answer from flops
    next_st.ready = 1'b0;
    next_st.err = 1'b0;
    if (psel && penable && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.err = !hit;
      next_st.rdata = (hit && !pwrite) ? rd : REG_RESET_VAL;
    end

    // writes land on the edge that completes the transfer
    if (psel && penable && st.ready && pwrite && hit) begin
      case (paddr)
        SWITCH_ENABLE_REG_A_OFS: begin
          for (int i = 0; i < NUM_BRIDGE; i++) begin
            next_st.upper_on[i] = pwdata[2*i+UPPER_BIT_POS];
            next_st.lower_on[i] = pwdata[2*i+LOWER_BIT_POS];
          end
        end
        CHOP_SELECT_REG_OFS: next_st.chop = pwdata[NUM_BRIDGE-1:0];
        FREEWHEEL_SELECT_REG_A_OFS: next_st.sync_fw = pwdata[NUM_BRIDGE-1:0];
        GENERATOR_MAP_REG_OFS: next_st.gen_sel = pwdata[NUM_BRIDGE*MAP_W-1:0];
        GENERATOR_RATE_REG_OFS: next_st.rate = pwdata[NUM_GEN*RATE_W-1:0];
        STATUS_REG_OFS: begin
        end
        default: begin
          for (int g = 0; g < NUM_GEN; g++) begin
            if (paddr == DUTY_REG_BASE_OFS + 8'(g) * REG_STRIDE) begin
              next_st.duty[g*DUTY_W +: DUTY_W] = pwdata[DUTY_W-1:0];
            end
          end
        end
      endcase
    end

    // switch drive per bridge
    awake = st.stby_s2;
    for (int i = 0; i < NUM_BRIDGE; i++) begin
      sel = st.gen_sel[i*MAP_W +: MAP_W];
      chopped = gen_pwm[sel];
      next_st.upper_drv[i] = 1'b0;
      next_st.lower_drv[i] = 1'b0;
      if (!awake) begin
        next_st.upper_drv[i] = 1'b0;
        next_st.lower_drv[i] = 1'b0;
      end else if (st.upper_on[i] && st.lower_on[i]) begin
        next_st.upper_drv[i] = 1'b0;
        next_st.lower_drv[i] = 1'b0;
      end else if (!st.chop[i]) begin
        next_st.upper_drv[i] = st.upper_on[i];
        next_st.lower_drv[i] = st.lower_on[i];
      end else if (st.upper_on[i]) begin
        next_st.upper_drv[i] = chopped;
        next_st.lower_drv[i] = st.sync_fw[i] && !chopped;
      end else if (st.lower_on[i]) begin
        next_st.lower_drv[i] = chopped;
        next_st.upper_drv[i] = st.sync_fw[i] && !chopped;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign bridge_upper_drive = st.upper_drv;
  assign bridge_lower_drive = st.lower_drv;
endmodule

// ### tb/hbc_load_model.sv
// behavioural model of the driven output pins of each half-bridge
`timescale 1ns/100ps
module hbc_load_model #(
  parameter int unsigned NUM_BRIDGE = 4
) (
  input wire logic [NUM_BRIDGE-1:0] bridge_upper_drive,
  input wire logic [NUM_BRIDGE-1:0] bridge_lower_drive,
  output logic [NUM_BRIDGE-1:0] pin_level,
  output logic [NUM_BRIDGE-1:0] pin_hiz
);
  // a floating pin reads low through the load, so level is only meaningful when not floating
  always_comb begin
    for (int i = 0; i < NUM_BRIDGE; i++) begin
      pin_hiz[i] = bridge_upper_drive[i] ~^ bridge_lower_drive[i];
      pin_level[i] = bridge_upper_drive[i] & !bridge_lower_drive[i];
    end
  end
endmodule

// ### tb/hbc_monitor.sv
// assertion checker on the ports of the half-bridge control top
`timescale 1ns/100ps
module hbc_monitor #(
  parameter int unsigned NUM_BRIDGE = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic standby_input_n,
  input wire logic [NUM_BRIDGE-1:0] bridge_upper_drive,
  input wire logic [NUM_BRIDGE-1:0] bridge_lower_drive
);
  logic chop0;
  // tracks the chop bit of bridge 0 so continuous checks skip chopping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop0 <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr && paddr == 8'h04) begin
      chop0 <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_awake; standby_input_n [*3]; endsequence
  sequence s_ctl_write; pready && pwrite && !pslverr && paddr == 8'h00 && !chop0; endsequence
  property p_wait_state; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  a_wait_state: assert property (p_wait_state) else $error("ready not one cycle into access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_high; pready && paddr >= 8'h30 |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_err_high: assert property (p_err_high) else $error("unmapped access not refused");
  property p_err_low; pready && paddr <= 8'h14 |-> !pslverr; endproperty
  a_err_low: assert property (p_err_low) else $error("mapped access refused");
  property p_err_only; pslverr |-> pready; endproperty
  a_err_only: assert property (p_err_only) else $error("error without ready");
  property p_no_shoot; (bridge_upper_drive & bridge_lower_drive) == '0; endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both switches of a bridge on");
  property p_standby; !standby_input_n [*3] |=> bridge_upper_drive == '0 && bridge_lower_drive == '0; endproperty
  a_standby: assert property (p_standby) else $error("drives on in standby");
  property p_reset_idle; $rose(presetn) |-> bridge_upper_drive == '0 && bridge_lower_drive == '0; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("drives on after reset");
  property p_cont_follow;
    s_awake ##0 s_ctl_write |-> ##2 bridge_upper_drive[0] == ($past(pwdata[0], 2) && !$past(pwdata[1], 2))
      && bridge_lower_drive[0] == (!$past(pwdata[0], 2) && $past(pwdata[1], 2));
  endproperty
  a_cont_follow: assert property (p_cont_follow) else $error("drive not following enables");
endmodule

bind hbc_top hbc_monitor #(.NUM_BRIDGE(NUM_BRIDGE)) u_hbc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .standby_input_n(standby_input_n), .bridge_upper_drive(bridge_upper_drive),
  .bridge_lower_drive(bridge_lower_drive));

// ### tb/tb_top.sv
// self-checking bench for the half-bridge control top
`timescale 1ns/100ps
module tb_top;
  import hbc_pkg::*;
  localparam int unsigned NB = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_input_n, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [NB-1:0] bridge_upper_drive, bridge_lower_drive, pin_level, pin_hiz;
  logic [7:0] duty_tab [4] = '{8'h00, 8'h40, 8'h80, 8'hFF};
  int miscompares = 0;
  int tests_run = 0;
  int up, lo;
  hbc_top #(.NUM_BRIDGE(NB), .NUM_GEN(4), .STEP_CLKS_0(4), .STEP_CLKS_1(3), .STEP_CLKS_2(2),
    .STEP_CLKS_3(1)) u_hbc_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_input_n(standby_input_n),
    .bridge_upper_drive(bridge_upper_drive), .bridge_lower_drive(bridge_lower_drive));
  hbc_load_model #(.NUM_BRIDGE(NB)) u_hbc_load_model (.bridge_upper_drive(bridge_upper_drive),
    .bridge_lower_drive(bridge_lower_drive), .pin_level(pin_level), .pin_hiz(pin_hiz));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic measure(input int n);
    up = 0;
    lo = 0;
    repeat (n) begin
      @(posedge pclk);
      if (bridge_upper_drive[0] === 1'b1) up++;
      if (bridge_lower_drive[0] === 1'b1) lo++;
    end
  endtask
  task automatic duty_run(input int per, input int hi_up, input int hi_lo);
    measure(per);
    measure(per);
    chk("upper_high_count", 32'(up), 32'(hi_up));
    chk("lower_high_count", 32'(lo), 32'(hi_lo));
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    presetn = 1'b0;
    standby_input_n = 1'b1;
    repeat (10) @(posedge pclk);
    chk("drives_in_reset", 32'({bridge_upper_drive, bridge_lower_drive}), 32'h0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, (i < 5) ? 8'(4 * i) : 8'(8'h20 + 4 * (i - 5)), 32'h0000_0000);
      chk("reset_value", rdv, 32'h0000_0000);
    end
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("status_awake", rdv, 32'h8000_0000);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h00, 32'(c) | (32'(3 - c) << 2));
      @(posedge pclk);
      chk("upper0", 32'(bridge_upper_drive[0]), 32'(c == 1));
      chk("lower0", 32'(bridge_lower_drive[0]), 32'(c == 2));
      chk("upper1", 32'(bridge_upper_drive[1]), 32'(c == 2));
      chk("hiz0", 32'(pin_hiz[0]), 32'(c == 0 || c == 3));
      chk("level0", 32'(pin_level[0]), 32'(c == 1));
    end
    apb(1'b1, 8'h00, 32'h0000_0001);
    standby_input_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("hiz_standby", 32'(pin_hiz), 32'h0000_000F);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("status_standby", rdv, 32'h0000_0000);
    standby_input_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("upper_wake", 32'(bridge_upper_drive[0]), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_00E4);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("rate_readback", rdv, 32'h0000_00E4);
    apb(1'b1, 8'h10, 32'h0000_0055);
    for (int g = 0; g < 4; g++) apb(1'b1, 8'(8'h20 + 4 * g), 32'(duty_tab[g]));
    apb(1'b1, 8'h00, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h0C, 32'(m));
      duty_run(768, 3 * duty_tab[m], 0);
    end
    apb(1'b1, 8'h10, 32'h0000_00E4);
    duty_run(256, 255, 0);
    apb(1'b1, 8'h0C, 32'h0000_0002);
    duty_run(512, 256, 0);
    apb(1'b1, 8'h0C, 32'h0000_0003);
    apb(1'b1, 8'h10, 32'h0000_0015);
    duty_run(1024, 1020, 0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    duty_run(1024, 1020, 4);
    apb(1'b1, 8'h00, 32'h0000_0002);
    duty_run(1024, 4, 1020);
    apb(1'b1, 8'h04, 32'h0000_0000);
    duty_run(1024, 0, 1024);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("err_read", {rdv[31:1], errv}, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk("err_write", 32'(errv), 32'h0000_0001);
    wrap_up();
  end
endmodule
